// ---- core/imv_pkg.sv ----
// package for the interrupt mask and vector block: register indices, field layouts, types
// assumes a single AHB-Lite slave port, word-aligned registers at four times their index
package imv_pkg;

  localparam int NUM_SRC = 24;
  localparam int DATA_W  = 32;
  localparam int EV_W    = 3;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLR0  = 8'hDA;
  localparam logic [7:0] IDX_CLR1  = 8'hDB;
  localparam logic [7:0] IDX_CLR2  = 8'hDC;
  localparam logic [7:0] IDX_MSK3  = 8'hDE;
  localparam logic [7:0] IDX_MSK2  = 8'hDF;
  localparam logic [7:0] IDX_MSK0  = 8'hE0;
  localparam logic [7:0] IDX_MSK1  = 8'hE1;
  localparam logic [7:0] IDX_VEC   = 8'hE2;
  localparam logic [7:0] IDX_ISTAT = 8'hE3;
  localparam logic [7:0] IDX_ICLR  = 8'hE4;
  localparam logic [7:0] IDX_IEN   = 8'hE5;

  // implemented bits per source group
  localparam logic [7:0] VALID_G0 = 8'hFF;
  localparam logic [7:0] VALID_G1 = 8'h7F;
  localparam logic [7:0] VALID_G2 = 8'h16;
  localparam logic [NUM_SRC-1:0] VALID_ALL = {VALID_G2, VALID_G1, VALID_G0};

  localparam int SWEN_BIT = 7;

  localparam logic [7:0]      MASK_RST = 8'h00;
  localparam logic            SWEN_RST = 1'b0;
  localparam logic [EV_W-1:0] EV_RST   = 3'h0;

  // vector of source i is VEC_BASE + i * VEC_STEP, none pending reads VEC_NONE
  localparam logic [7:0] VEC_BASE = 8'h04;
  localparam logic [7:0] VEC_STEP = 8'h04;
  localparam logic [7:0] VEC_NONE = 8'h00;

  // event status bits
  localparam int EV_PEND   = 0;
  localparam int EV_FLUSH  = 1;
  localparam int EV_SWPOST = 2;

  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    IMV_BUS_IDLE = 1'b0,
    IMV_BUS_WAIT = 1'b1
  } imv_bus_t;

  typedef struct packed {
    logic              hsel;
    logic [1:0]        htrans;
    logic [31:0]       haddr;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic              hready;
  } imv_ahb_in_t;

endpackage

// ---- core/imv_post_bank.sv ----
// posted-flag bank: one sticky flag per interrupt source
// assumes set and clear vectors come from logic on the same clock
`timescale 1ns/100ps
module imv_post_bank (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic [imv_pkg::NUM_SRC-1:0] setVec,
  input  wire logic [imv_pkg::NUM_SRC-1:0] clrVec,
  output logic      [imv_pkg::NUM_SRC-1:0] postedVec
);
  import imv_pkg::*;

  typedef struct packed {
    logic [NUM_SRC-1:0] posted;
  } imv_bank_st_t;

  imv_bank_st_t bank_ff;
  imv_bank_st_t nxt_bank;

  always_comb begin
    nxt_bank = bank_ff;
    for (int i = 0; i < NUM_SRC; i++) begin
      // set beats a clear in the same cycle
      nxt_bank.posted[i] = setVec[i] | (bank_ff.posted[i] & ~clrVec[i]);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_ff <= '0;
    end else begin
      bank_ff <= nxt_bank;
    end
  end

  assign postedVec = bank_ff.posted;

endmodule

// ---- core/imv_vec_enc.sv ----
// priority encoder: lowest source index wins, gives its vector and a one-hot select
// assumes pending already gated by the masks
`timescale 1ns/100ps
module imv_vec_enc (
  input  wire logic [imv_pkg::NUM_SRC-1:0] pendingVec,
  output logic      [7:0]                  vector,
  output logic      [imv_pkg::NUM_SRC-1:0] winSel
);
  import imv_pkg::*;

  always_comb begin
    vector = VEC_NONE;
    winSel = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pendingVec[i]) begin
        vector = 8'(VEC_BASE + 8'(i) * VEC_STEP);
        winSel = '0;
        winSel[i] = 1'b1;
      end
    end
  end

endmodule

// ---- core/imv_top.sv ----
// interrupt mask and vector block: masks, post/clear, vector read and flush, event irq
// assumes one AHB-Lite master, sources and cpu handshake on mclk, single word transfers
// Function
// - a source whose mask bit is zero never becomes pending.
// - a source event posts its flag even while its mask bit is zero.
// - each mask bit acts on its own source and writing one leaves the others alone.
// - a source whose mask bit is one becomes pending when posted and feeds the encoder.
// - with software post off, a written zero clears the posted flag and a one does nothing.
// - with software post on, a written one posts the flag and a zero does nothing.
// - software post enable is bit 7 of the fourth mask register, reset zero, bits 6:0 reserved.
// - third mask register bit 4 is gpio port 2, bit 2 third external line, bit 1 counter wrap.
// - second mask register bits 6 to 0 are interval timer, 1 ms timer, usb active, reset, ep2-0.
// - first mask register bits 7 to 0 are gpio1, sleep, line two, gpio0, spi rx, spi tx, line one, por.
// - mask bits mean masked at zero and unmasked at one, and all reset to zero.
// - reading the vector register returns the vector of the highest priority pending source.
// - any write to the vector register clears all pending interrupts.
// - a posted flag holds until taken or cleared by software, masking does not clear it.
// - the encoder picks the highest pending source and it is taken only with the global enable set.
// - reading a post/clear register shows posted flags in the mask register layout.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
module imv_top (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire imv_pkg::imv_ahb_in_t        ahbIn,
  output logic                             hreadyout,
  output logic      [imv_pkg::DATA_W-1:0]  hrdata,
  output logic                             hresp,
  input  wire logic [imv_pkg::NUM_SRC-1:0] srcEvent,
  input  wire logic                        gieFlag,
  input  wire logic                        cpuTake,
  output logic                             intReq,
  output logic      [7:0]                  intVector,
  output logic                             irqOut
);
  import imv_pkg::*;

  typedef struct packed {
    imv_bus_t           bus;
    logic [7:0]         idx;
    logic               wr;
    logic [NUM_SRC-1:0] mask;
    logic               swEn;
    logic [EV_W-1:0]    stat;
    logic [EV_W-1:0]    ien;
    logic               anyPendPrev;
    logic               intReq;
    logic [7:0]         vec;
    logic               irq;
    logic               readyOut;
    logic [DATA_W-1:0]  rdata;
  } imv_top_st_t;

  imv_top_st_t        top_ff;
  imv_top_st_t        nxt_top;
  logic [NUM_SRC-1:0] postedVec;
  logic [NUM_SRC-1:0] pendingVec;
  logic [NUM_SRC-1:0] winSel;
  logic [7:0]         vecNow;
  logic [NUM_SRC-1:0] setVec;
  logic [NUM_SRC-1:0] clrVec;
  logic [NUM_SRC-1:0] swSet;
  logic [NUM_SRC-1:0] swClr;
  logic [NUM_SRC-1:0] takeClr;
  logic [EV_W-1:0]    evNow;
  logic [EV_W-1:0]    evClr;
  logic               flush;
  logic               accept;
  logic               wrCommit;
  logic [7:0]         wrByte;

  // word index of an address, all ones when outside the block
  function automatic logic [7:0] addrIdx(input logic [31:0] addr);
    if (addr[31:10] != 22'h0) begin
      return 8'hFF;
    end
    return addr[9:2];
  endfunction

  // source group addressed by a post/clear or mask index, 3 when none
  function automatic logic [1:0] groupOf(input logic [7:0] idx);
    unique case (idx)
      IDX_CLR0, IDX_MSK0: return 2'h0;
      IDX_CLR1, IDX_MSK1: return 2'h1;
      IDX_CLR2, IDX_MSK2: return 2'h2;
      default:            return 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] groupByte(input logic [NUM_SRC-1:0] v, input logic [1:0] g);
    unique case (g)
      2'h0:    return v[7:0];
      2'h1:    return v[15:8];
      2'h2:    return v[23:16];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [NUM_SRC-1:0] toGroup(input logic [7:0] b, input logic [1:0] g);
    unique case (g)
      2'h0:    return {16'h0000, b};
      2'h1:    return {8'h00, b, 8'h00};
      2'h2:    return {b, 16'h0000};
      default: return '0;
    endcase
  endfunction

  assign pendingVec = postedVec & top_ff.mask;

  imv_post_bank u_bank (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .setVec    (setVec),
    .clrVec    (clrVec),
    .postedVec (postedVec)
  );

  imv_vec_enc u_enc (
    .pendingVec (pendingVec),
    .vector     (vecNow),
    .winSel     (winSel)
  );

  always_comb begin
    nxt_top  = top_ff;
    swSet    = '0;
    swClr    = '0;
    evClr    = '0;
    flush    = 1'b0;
    accept   = ahbIn.hsel && ahbIn.htrans[1] && ahbIn.hready;
    wrCommit = (top_ff.bus == IMV_BUS_WAIT) && top_ff.wr;
    wrByte   = ahbIn.hwdata[7:0];
    unique case (top_ff.bus)
      IMV_BUS_IDLE: begin
        if (accept) begin
          nxt_top.bus      = IMV_BUS_WAIT;
          nxt_top.idx      = addrIdx(ahbIn.haddr);
          nxt_top.wr       = ahbIn.hwrite;
          nxt_top.readyOut = 1'b0;
        end
      end
      IMV_BUS_WAIT: begin
        nxt_top.bus      = IMV_BUS_IDLE;
        nxt_top.readyOut = 1'b1;
        nxt_top.rdata    = '0;
        if (top_ff.wr) begin
          unique case (top_ff.idx)
            IDX_CLR0, IDX_CLR1, IDX_CLR2: begin
              if (top_ff.swEn) begin
                swSet = toGroup(wrByte, groupOf(top_ff.idx)) & VALID_ALL;
              end else begin
                swClr = toGroup(~wrByte, groupOf(top_ff.idx)) & VALID_ALL;
              end
            end
            IDX_MSK0, IDX_MSK1, IDX_MSK2: begin
              // only the addressed group changes, reserved bits stay zero
              nxt_top.mask = (top_ff.mask & ~toGroup(8'hFF, groupOf(top_ff.idx)))
                | (toGroup(wrByte, groupOf(top_ff.idx)) & VALID_ALL);
            end
            IDX_MSK3: nxt_top.swEn = wrByte[SWEN_BIT];
            IDX_VEC:  flush = 1'b1;
            IDX_ICLR: evClr = ahbIn.hwdata[EV_W-1:0];
            IDX_IEN:  nxt_top.ien = ahbIn.hwdata[EV_W-1:0];
            default: ;
          endcase
        end else begin
          unique case (top_ff.idx)
            IDX_CLR0, IDX_CLR1, IDX_CLR2: begin
              nxt_top.rdata[7:0] = groupByte(postedVec, groupOf(top_ff.idx));
            end
            IDX_MSK0, IDX_MSK1, IDX_MSK2: begin
              nxt_top.rdata[7:0] = groupByte(top_ff.mask, groupOf(top_ff.idx));
            end
            IDX_MSK3:  nxt_top.rdata[SWEN_BIT] = top_ff.swEn;
            IDX_VEC:   nxt_top.rdata[7:0] = vecNow;
            IDX_ISTAT: nxt_top.rdata[EV_W-1:0] = top_ff.stat;
            IDX_IEN:   nxt_top.rdata[EV_W-1:0] = top_ff.ien;
            default: ;
          endcase
        end
      end
    endcase

    takeClr = (cpuTake && gieFlag) ? winSel : '0;
    setVec  = (srcEvent & VALID_ALL) | swSet;
    clrVec  = swClr | takeClr | (flush ? pendingVec : '0);

    evNow            = '0;
    evNow[EV_PEND]   = (|pendingVec) && !top_ff.anyPendPrev;
    evNow[EV_FLUSH]  = flush;
    evNow[EV_SWPOST] = |swSet;
    // a new event wins over a software clear
    nxt_top.stat        = evNow | (top_ff.stat & ~evClr);
    nxt_top.irq         = |(nxt_top.stat & nxt_top.ien);
    nxt_top.anyPendPrev = |pendingVec;
    nxt_top.intReq      = (|pendingVec) && gieFlag;
    nxt_top.vec         = vecNow;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      top_ff          <= '0;
      top_ff.mask     <= {MASK_RST, MASK_RST, MASK_RST};
      top_ff.swEn     <= SWEN_RST;
      top_ff.stat     <= EV_RST;
      top_ff.ien      <= EV_RST;
      top_ff.readyOut <= 1'b1;
    end else begin
      top_ff <= nxt_top;
    end
  end

  assign hreadyout = top_ff.readyOut;
  assign hrdata    = top_ff.rdata;
  assign hresp     = HRESP_OKAY;
  assign intReq    = top_ff.intReq;
  assign intVector = top_ff.vec;
  assign irqOut    = top_ff.irq;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic [NUM_SRC-1:0] evMasked;
  logic               wrClr0;
  assign evMasked = srcEvent & ~top_ff.mask & VALID_ALL;
  assign wrClr0   = wrCommit && (top_ff.idx == IDX_CLR0);

  chk_masked_silent: assert property ((top_ff.mask == '0) |=> (intVector == VEC_NONE))
    else $error("masked sources produced a vector");
  chk_post_masked: assert property (
    (evMasked != '0) |=> ((postedVec & $past(evMasked)) == $past(evMasked)))
    else $error("event on masked source did not post");
  chk_mask_isolate: assert property (
    (wrCommit && top_ff.idx == IDX_MSK0) |=> ($stable(top_ff.mask[23:8]) && $stable(top_ff.swEn)))
    else $error("mask write disturbed another group");
  chk_unmask_pend: assert property (((|pendingVec) && gieFlag) |=> intReq)
    else $error("pending source gave no request");
  chk_clr_zero: assert property (
    (wrClr0 && !top_ff.swEn && !ahbIn.hwdata[0] && !srcEvent[0]) |=> !postedVec[0])
    else $error("written zero did not clear posted flag");
  chk_clr_one_keep: assert property (
    (wrClr0 && !top_ff.swEn && ahbIn.hwdata[0] && postedVec[0] && !takeClr[0])
    |=> postedVec[0])
    else $error("written one cleared posted flag");
  chk_sw_post: assert property ((wrClr0 && top_ff.swEn && ahbIn.hwdata[0]) |=> postedVec[0])
    else $error("software post did not set flag");
  chk_sw_zero_ign: assert property (
    (wrClr0 && top_ff.swEn && !ahbIn.hwdata[0] && postedVec[0] && !takeClr[0])
    |=> postedVec[0])
    else $error("written zero with software post cleared flag");
  chk_reset_state: assert property (
    $past(sys_rst) |-> (top_ff.mask == '0 && !top_ff.swEn && hreadyout))
    else $error("masks not cleared after reset");
  chk_vector_read: assert property (
    (top_ff.bus == IMV_BUS_WAIT && !top_ff.wr && top_ff.idx == IDX_VEC)
    |=> (hrdata == {24'h0, $past(vecNow)} && hreadyout))
    else $error("vector read returned wrong value");
  chk_flush_all: assert property (
    (wrCommit && top_ff.idx == IDX_VEC && srcEvent == '0) |=> (pendingVec == '0))
    else $error("vector write left a pending source");
  chk_posted_hold: assert property (
    1'b1 |=> ((($past(postedVec) & ~postedVec) & ~$past(clrVec)) == '0))
    else $error("posted flag dropped without a clear");
  chk_req_gated: assert property (!gieFlag |=> !intReq)
    else $error("request raised with global enable clear");
  chk_resv_zero: assert property (
    ((top_ff.mask & ~VALID_ALL) == '0) && ((postedVec & ~VALID_ALL) == '0))
    else $error("reserved bit became set");

  // bus handshake: one wait state, then ready again
  chk_wait_one: assert property (
    (top_ff.bus == IMV_BUS_WAIT) |=> (top_ff.bus == IMV_BUS_IDLE && hreadyout))
    else $error("data phase longer than one wait state");
  chk_accept_low: assert property (
    (accept && top_ff.bus == IMV_BUS_IDLE) |=> !hreadyout)
    else $error("accepted transfer gave no wait state");
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  chk_swen_write: assert property (
    (wrCommit && top_ff.idx == IDX_MSK3) |=> (top_ff.swEn == $past(ahbIn.hwdata[SWEN_BIT])))
    else $error("software post enable not written");
  chk_swen_resv: assert property (
    (top_ff.bus == IMV_BUS_WAIT && !top_ff.wr && top_ff.idx == IDX_MSK3)
    |=> (hrdata[6:0] == 7'h00 && hrdata[31:8] == 24'h000000))
    else $error("reserved bits of fourth mask register read nonzero");
  chk_swen_isolate: assert property (
    (wrCommit && top_ff.idx == IDX_MSK3) |=> $stable(top_ff.mask))
    else $error("software post enable write changed a mask");
  chk_mask0_write: assert property (
    (wrCommit && top_ff.idx == IDX_MSK0)
    |=> (top_ff.mask[7:0] == ($past(ahbIn.hwdata[7:0]) & VALID_G0)))
    else $error("first mask register not written");
  chk_mask1_write: assert property (
    (wrCommit && top_ff.idx == IDX_MSK1)
    |=> (top_ff.mask[15:8] == ($past(ahbIn.hwdata[7:0]) & VALID_G1)))
    else $error("second mask register not written");
  chk_mask2_write: assert property (
    (wrCommit && top_ff.idx == IDX_MSK2)
    |=> (top_ff.mask[23:16] == ($past(ahbIn.hwdata[7:0]) & VALID_G2)))
    else $error("third mask register not written");
  chk_post_read: assert property (
    (top_ff.bus == IMV_BUS_WAIT && !top_ff.wr && top_ff.idx == IDX_CLR0)
    |=> (hrdata[7:0] == $past(postedVec[7:0])))
    else $error("post/clear read did not show posted flags");
  chk_take_gated: assert property (
    (cpuTake && !gieFlag && srcEvent == '0 && !wrCommit)
    |=> (postedVec == $past(postedVec)))
    else $error("take honoured with global enable clear");
  chk_take_winner: assert property (
    (cpuTake && gieFlag && srcEvent == '0 && !wrCommit && pendingVec != '0)
    |=> ((postedVec & $past(winSel)) == '0))
    else $error("taken winner still posted");
  chk_top_prio: assert property (pendingVec[0] |=> (intVector == VEC_BASE))
    else $error("highest priority source not selected");

  cov_sw_post: cover property (wrClr0 && top_ff.swEn && ahbIn.hwdata[0]);
  cov_flush:   cover property (wrCommit && top_ff.idx == IDX_VEC && pendingVec != '0);
  cov_take:    cover property (cpuTake && gieFlag && pendingVec != '0);
  cov_irq:     cover property (irqOut);
  cov_mask3:   cover property (wrCommit && top_ff.idx == IDX_MSK3);

endmodule

// ---- tb/imv_cpu_model.sv ----
// cpu-side bus master model: single-word AHB-Lite transfers into the interrupt block
// assumes hready is fed back from the block's hreadyout, everything on mclk
`timescale 1ns/100ps
module imv_cpu_model (
  input  wire logic         mclk,
  input  wire logic         hreadyout,
  input  wire logic [31:0]  hrdata,
  output imv_pkg::imv_ahb_in_t cpuBus,
  output logic              rdValid,
  output logic [31:0]       rdData
);
  import imv_pkg::*;

  initial begin
    cpuBus  = '0;
    rdValid = 1'b0;
    rdData  = '0;
  end

  always @(posedge mclk) begin
    if (rdValid) begin
      rdValid <= 1'b0;
    end
  end

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    cpuBus.hsel   <= 1'b1;
    cpuBus.htrans <= 2'b10;
    cpuBus.haddr  <= {22'h0, idx, 2'b00};
    cpuBus.hwrite <= wr;
    cpuBus.hsize  <= 3'b010;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    cpuBus.htrans <= 2'b00;
    cpuBus.hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdData  <= hrdata;
    rdValid <= ~wr;
  endtask
endmodule

// ---- tb/imv_bench.sv ----
// self-checking bench for the interrupt mask and vector block
// assumes the cpu model drives the bus; read results are checked from a queue
`timescale 1ns/100ps
module imv_bench;
  import imv_pkg::*;
  logic                mclk     = 1'b0;
  logic                sys_rst  = 1'b1;
  logic                gieFlag  = 1'b0;
  logic                cpuTake  = 1'b0;
  logic [NUM_SRC-1:0]  srcEvent = '0;
  logic                hreadyout, hresp, intReq, irqOut, rdValid;
  logic [31:0]         hrdata, rdData, expD, rw;
  logic [7:0]          intVector;
  imv_ahb_in_t         cpuBus, ahbIn;
  logic [31:0]         expQ[$];
  logic [7:0]          mSet[4];
  logic [7:0]          mIdx[4] = '{IDX_MSK0, IDX_MSK1, IDX_MSK2, IDX_MSK3};
  logic [7:0]          mVal[4] = '{VALID_G0, VALID_G1, VALID_G2, 8'h80};
  logic [7:0]          rTab[11] = '{IDX_CLR0, IDX_CLR1, IDX_CLR2, IDX_MSK3, IDX_MSK2,
                                    IDX_MSK0, IDX_MSK1, IDX_VEC, IDX_ISTAT, IDX_IEN, 8'hD0};
  int                  n_mismatch = 0;
  int                  cmp_count  = 0;
  int                  cycles     = 0;
  int                  seed       = 53;

  always #4 mclk = ~mclk;

  always_comb begin
    ahbIn        = cpuBus;
    ahbIn.hready = hreadyout;
  end

  imv_top imv_top_inst (.mclk(mclk), .sys_rst(sys_rst), .ahbIn(ahbIn), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .srcEvent(srcEvent), .gieFlag(gieFlag), .cpuTake(cpuTake),
    .intReq(intReq), .intVector(intVector), .irqOut(irqOut));

  imv_cpu_model imv_cpu_model_inst (.mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata),
    .cpuBus(cpuBus), .rdValid(rdValid), .rdData(rdData));

  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic sig(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) bad(m);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    expQ.push_back({24'h0, exp});
    imv_cpu_model_inst.xfer(1'b0, idx, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    imv_cpu_model_inst.xfer(1'b1, idx, {r[31:8], d});
  endtask

  task automatic pulse(input logic [NUM_SRC-1:0] ev, input logic tk);
    srcEvent <= ev;
    cpuTake  <= tk;
    @(posedge mclk);
    srcEvent <= '0;
    cpuTake  <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  function automatic logic [7:0] vecOf(input int i);
    return VEC_BASE + 8'(i) * VEC_STEP;
  endfunction

  // read results in issue order
  always @(posedge mclk) begin
    if (rdValid) begin
      cmp_count++;
      if (expQ.size() == 0) begin
        bad("read with no expectation");
      end else begin
        expD = expQ.pop_front();
        if (rdData !== expD) bad($sformatf("read %h expected %h", rdData, expD));
      end
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad("timeout");
      finish_test();
    end
  end

  task automatic finish_test;
    if (expQ.size() != 0) bad("reads missing");
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rTab[i]) rd(rTab[i], 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rw = $random(seed);
      mSet[i] = rw[7:0];
      wr(mIdx[i], mSet[i]);
      rd(mIdx[i], mSet[i] & mVal[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(mIdx[i], mSet[i] & mVal[i]);
      wr(mIdx[i], 8'h00);
    end
    $display("test masks done");
    gieFlag <= 1'b1;
    pulse('1, 1'b0);
    sig({7'h0, intReq}, 8'h00, "masked source requested");
    rd(IDX_CLR0, VALID_G0);
    rd(IDX_CLR1, VALID_G1);
    rd(IDX_CLR2, VALID_G2);
    rd(IDX_VEC, VEC_NONE);
    wr(IDX_MSK1, 8'h08);
    rd(IDX_VEC, vecOf(11));
    sig(intVector, vecOf(11), "vector output");
    wr(IDX_MSK0, 8'h20);
    rd(IDX_VEC, vecOf(5));
    sig({7'h0, intReq}, 8'h01, "no request");
    sig({7'h0, hresp}, 8'h00, "response not okay");
    wr(IDX_MSK0, 8'h00);
    wr(IDX_MSK1, 8'h00);
    rd(IDX_CLR0, VALID_G0);
    rd(IDX_VEC, VEC_NONE);
    $display("test pending done");
    wr(IDX_CLR0, 8'hFE);
    rd(IDX_CLR0, 8'hFE);
    wr(IDX_MSK3, 8'h80);
    wr(IDX_CLR2, 8'h00);
    rd(IDX_CLR2, VALID_G2);
    wr(IDX_CLR0, 8'h01);
    rd(IDX_CLR0, 8'hFF);
    wr(IDX_MSK3, 8'h00);
    $display("test post clear done");
    wr(IDX_MSK0, 8'h03);
    rw = $random(seed);
    wr(IDX_VEC, rw[7:0]);
    rd(IDX_CLR0, 8'hFC);
    rd(IDX_VEC, VEC_NONE);
    wr(IDX_MSK1, 8'h7F);
    gieFlag <= 1'b0;
    pulse('0, 1'b1);
    rd(IDX_CLR1, VALID_G1);
    gieFlag <= 1'b1;
    pulse('0, 1'b1);
    rd(IDX_CLR1, 8'h7E);
    rd(IDX_VEC, vecOf(9));
    $display("test flush and take done");
    rd(IDX_ISTAT, 8'h07);
    wr(IDX_IEN, 8'h02);
    pulse('0, 1'b0);
    sig({7'h0, irqOut}, 8'h01, "irq not raised");
    wr(IDX_IEN, 8'h00);
    pulse('0, 1'b0);
    sig({7'h0, irqOut}, 8'h00, "irq not masked");
    wr(IDX_IEN, 8'h02);
    wr(IDX_ICLR, 8'h02);
    pulse('0, 1'b0);
    sig({7'h0, irqOut}, 8'h00, "irq not cleared");
    rd(IDX_ISTAT, 8'h05);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'h00);
    $display("test events done");
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule
